// ==== hdl/srv_pkg.sv ====
// Constants, types and register map of the system reset and NMI vector unit
// Notes on behaviour
// - Three read-only vectors at 015Eh, 015Ch, 015Ah give top pending code or 00h.
// - Reset cause: brownout 02h highest, reset pin 04h, software brownout 06h.
// - Reset cause: deep-sleep wake 08h, security 0Ah, supervisor 0Eh; 0Ch reserved.
// - Reset cause: software power-on 14h; codes 10h and 12h reserved.
// - Reset cause: watchdog time-out gives 16h, a power-up-clear reset.
// - Reset cause: wrong watchdog password write gives 18h and triggers power-up-clear.
// - Reset cause: memory controller password violation gives 1Ah.
// - Uncorrectable memory bit error: 1Ch in reset cause, 04h in system NMI.
// - Reset cause: fetch from peripheral area gives 1Eh.
// - Reset cause: power-manager password 20h, lock loss 24h; 22h, 26h-3Eh reserved.
// - System NMI: supervisor low-power reset entry 02h highest; 06h-10h reserved.
// - System NMI: vacant memory access gives 12h.
// - System NMI: mailbox input pending 14h, mailbox output pending 16h.
// - System NMI: correctable bit error 18h; 1Ah-1Eh reserved, lowest.
// - User NMI: NMI pin 02h highest, oscillator fault 04h; rest reserved.
// - Watchdog mode: unserviced interval expiry generates a system reset.
// - Interval mode: each expiry raises an interrupt instead of a reset.
// - Watchdog clock select: 00 sub-main, 01 auxiliary, 10 very-low oscillator, 11 reserved.
// - Mailbox joins debug link and application; its events feed system NMI.
package srv_pkg;

  localparam logic [15:0] ADDR_UNMI = 16'h015A;
  localparam logic [15:0] ADDR_SNMI = 16'h015C;
  localparam logic [15:0] ADDR_RST = 16'h015E;
  localparam logic [15:0] ADDR_WDCTL = 16'h01CC;
  localparam logic [15:0] ADDR_MBIN = 16'h0120;
  localparam logic [15:0] ADDR_MBOUT = 16'h0122;

  // Flag index i reports code 2*i
  localparam int RST_N = 31;
  localparam int NMI_N = 15;
  localparam int RI_BROWNOUT = 1;
  localparam int RI_PIN = 2;
  localparam int RI_SWBOR = 3;
  localparam int RI_WAKE = 4;
  localparam int RI_SEC = 5;
  localparam int RI_SUP = 7;
  localparam int RI_SWPOR = 10;
  localparam int RI_WDTO = 11;
  localparam int RI_WDPW = 12;
  localparam int RI_NVPW = 13;
  localparam int RI_UNCOR = 14;
  localparam int RI_PFETCH = 15;
  localparam int RI_PMPW = 16;
  localparam int RI_LOCK_LOSS = 18;
  localparam int SI_SVS = 1;
  localparam int SI_UNCOR = 2;
  localparam int SI_VAC = 9;
  localparam int SI_MBIN = 10;
  localparam int SI_MBOUT = 11;
  localparam int SI_COR = 12;
  localparam int UI_NMI = 1;
  localparam int UI_OSC = 2;

  // Watchdog control word layout
  localparam int WD_PW_LO = 8;
  localparam int WD_HOLD = 7;
  localparam int WD_SSEL_LO = 5;
  localparam int WD_TMSEL = 4;
  localparam int WD_CNTCL = 3;
  localparam int WD_IS_LO = 0;
  localparam logic [7:0] WD_PASSWORD = 8'hA5;
  localparam logic [7:0] WD_CTL_RST = 8'h00;
  localparam int WD_TAP0 = 15;
  localparam int WD_TAP1 = 13;
  localparam int WD_TAP2 = 9;
  localparam int WD_TAP3 = 6;

  localparam int CLR_PULSE_NS = 200;
  localparam int CLK_NS = 50;
  localparam int CLR_PULSE_CYC = (CLR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUB_DIV = 2;

  typedef enum logic [1:0] {
    SRV_WCK_SUB = 2'b00,
    SRV_WCK_AUX = 2'b01,
    SRV_WCK_VLO = 2'b10,
    SRV_WCK_RSV = 2'b11
  } srv_wck_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } srv_per_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] wdata;
  } srv_dbg_req_t;

  typedef struct packed {
    logic pin_rst;
    logic soft_bor;
    logic wake;
    logic security;
    logic supply;
    logic soft_por;
    logic nvm_pw;
    logic nvm_uncorr;
    logic periph_fetch;
    logic power_pw;
    logic fll_unlock;
    logic svs_lpm;
    logic vacant;
    logic nvm_corr;
    logic nmi_pin;
    logic osc_fault;
  } srv_evt_t;

endpackage

// ==== hdl/srv_prio_vec.sv ====
// Sticky flag set with lowest-index-first priority code and read clear
`timescale 1ns/1ps
module srv_prio_vec #(
  parameter int N = 15,
  parameter logic [N:0] RST_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [N:0] set_i,
  input wire logic [N:0] clr_i,
  input wire logic take_i,
  output logic [15:0] code_o,
  output logic pend_o
);
  typedef struct packed {
    logic [N:0] flags;
  } srv_pv_st_t;

  srv_pv_st_t st;
  srv_pv_st_t next_st;
  logic [N:0] top_hot;

  always_comb begin
    code_o = 16'h0000;
    top_hot = '0;
    for (int i = N; i >= 1; i--) begin
      if (st.flags[i]) begin
        code_o = 16'(i * 2);
        top_hot = '0;
        top_hot[i] = 1'b1;
      end
    end
    pend_o = |st.flags;
    next_st = st;
    // Set wins over both clears so no event is lost
    next_st.flags = (st.flags & ~clr_i & ~(take_i ? top_hot : '0)) | set_i;
    next_st.flags[0] = 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st.flags <= RST_VAL;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ==== hdl/srv_wdog.sv ====
// Watchdog counter with selectable clock enable and interval tap
`timescale 1ns/1ps
module srv_wdog #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sub_tick_i,
  input wire logic aux_tick_i,
  input wire logic vlo_tick_i,
  input srv_pkg::srv_wck_t ssel_i,
  input wire logic hold_i,
  input wire logic clr_i,
  input wire logic [1:0] isel_i,
  output logic expire_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic expire;
  } srv_wd_st_t;

  srv_wd_st_t st;
  srv_wd_st_t next_st;
  logic tick;
  logic [CNT_W-1:0] term;

  always_comb begin
    case (ssel_i)
      srv_pkg::SRV_WCK_SUB: tick = sub_tick_i;
      srv_pkg::SRV_WCK_AUX: tick = aux_tick_i;
      srv_pkg::SRV_WCK_VLO: tick = vlo_tick_i;
      default: tick = 1'b0;
    endcase
    case (isel_i)
      2'b00: term = CNT_W'((64'd1 << srv_pkg::WD_TAP0) - 64'd1);
      2'b01: term = CNT_W'((64'd1 << srv_pkg::WD_TAP1) - 64'd1);
      2'b10: term = CNT_W'((64'd1 << srv_pkg::WD_TAP2) - 64'd1);
      default: term = CNT_W'((64'd1 << srv_pkg::WD_TAP3) - 64'd1);
    endcase
    next_st = st;
    next_st.expire = 1'b0;
    if (clr_i) begin
      next_st.cnt = '0;
    end else if (tick && !hold_i) begin
      if (st.cnt >= term) begin
        next_st.cnt = '0;
        next_st.expire = 1'b1;
      end else begin
        next_st.cnt = st.cnt + CNT_W'(1);
      end
    end
    expire_o = st.expire;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ==== hdl/srv_top.sv ====
// System reset and NMI vector unit with watchdog and debug mailbox
`timescale 1ns/1ps
module srv_top #(
  parameter int SUB_MAIN_DIV = srv_pkg::SUB_DIV,
  parameter int WD_CNT_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input srv_pkg::srv_per_req_t per_req_i,
  output logic [15:0] per_rdata_o,
  input srv_pkg::srv_dbg_req_t dbg_req_i,
  output logic [15:0] dbg_rdata_o,
  output logic dbg_out_full_o,
  input srv_pkg::srv_evt_t evt_i,
  input wire logic aux_tick_i,
  input wire logic vlo_tick_i,
  output logic wdog_reset_o,
  output logic wdog_irq_o,
  output logic snmi_pend_o,
  output logic unmi_pend_o
);
  localparam logic [7:0] CLR_LEN = 8'(srv_pkg::CLR_PULSE_CYC);
  localparam logic [7:0] DIV_LAST = 8'(SUB_MAIN_DIV - 1);

  typedef struct packed {
    logic [15:0] rdata;
    logic [7:0] sub_cnt;
    logic sub_tick;
    logic wd_hold;
    logic [1:0] wd_ssel;
    logic wd_tmsel;
    logic [1:0] wd_isel;
    logic wd_clr;
    logic [7:0] clr_cnt;
    logic clr_pulse;
    logic irq;
    logic [15:0] mb_in;
    logic [15:0] mb_out;
    logic out_full;
    logic [15:0] dbg_rdata;
    logic snmi_p;
    logic unmi_p;
    logic nmi_pin_d;
  } srv_top_st_t;

  srv_top_st_t st;
  srv_top_st_t next_st;

  logic wd_expire;
  logic wd_write;
  logic wd_pw_bad;
  logic rd_rst;
  logic rd_snmi;
  logic rd_unmi;
  logic [srv_pkg::RST_N:0] rst_set;
  logic [srv_pkg::NMI_N:0] snmi_set;
  logic [srv_pkg::NMI_N:0] snmi_clr;
  logic [srv_pkg::NMI_N:0] unmi_set;
  logic [15:0] rst_code;
  logic [15:0] snmi_code;
  logic [15:0] unmi_code;
  logic snmi_pend;
  logic unmi_pend;

  // Brownout is the only reset of this block, so its cause is pending at release
  localparam logic [srv_pkg::RST_N:0] RST_CAUSE_INIT = (srv_pkg::RST_N + 1)'(1) << srv_pkg::RI_BROWNOUT;

  // Decode of bus strobes
  always_comb begin
    rd_rst = per_req_i.rd && (per_req_i.addr == srv_pkg::ADDR_RST);
    rd_snmi = per_req_i.rd && (per_req_i.addr == srv_pkg::ADDR_SNMI);
    rd_unmi = per_req_i.rd && (per_req_i.addr == srv_pkg::ADDR_UNMI);
    wd_write = per_req_i.wr && (per_req_i.addr == srv_pkg::ADDR_WDCTL);
    wd_pw_bad = wd_write && (per_req_i.wdata[15:srv_pkg::WD_PW_LO] != srv_pkg::WD_PASSWORD);
  end

  // Reset-cause sources; reserved indices stay zero
  always_comb begin
    rst_set = '0;
    rst_set[srv_pkg::RI_PIN] = evt_i.pin_rst;
    rst_set[srv_pkg::RI_SWBOR] = evt_i.soft_bor;
    rst_set[srv_pkg::RI_WAKE] = evt_i.wake;
    rst_set[srv_pkg::RI_SEC] = evt_i.security;
    rst_set[srv_pkg::RI_SUP] = evt_i.supply;
    rst_set[srv_pkg::RI_SWPOR] = evt_i.soft_por;
    rst_set[srv_pkg::RI_WDTO] = wd_expire && !st.wd_tmsel;
    rst_set[srv_pkg::RI_WDPW] = wd_pw_bad;
    rst_set[srv_pkg::RI_NVPW] = evt_i.nvm_pw;
    rst_set[srv_pkg::RI_UNCOR] = evt_i.nvm_uncorr;
    rst_set[srv_pkg::RI_PFETCH] = evt_i.periph_fetch;
    rst_set[srv_pkg::RI_PMPW] = evt_i.power_pw;
    rst_set[srv_pkg::RI_LOCK_LOSS] = evt_i.fll_unlock;
  end

  // System NMI sources, mailbox events among them
  always_comb begin
    snmi_set = '0;
    snmi_set[srv_pkg::SI_SVS] = evt_i.svs_lpm;
    snmi_set[srv_pkg::SI_UNCOR] = evt_i.nvm_uncorr;
    snmi_set[srv_pkg::SI_VAC] = evt_i.vacant;
    snmi_set[srv_pkg::SI_MBIN] = dbg_req_i.wr;
    snmi_set[srv_pkg::SI_MBOUT] = dbg_req_i.rd && st.out_full;
    snmi_set[srv_pkg::SI_COR] = evt_i.nvm_corr;
    snmi_clr = '0;
    // Taking the input word also retires its pending event
    snmi_clr[srv_pkg::SI_MBIN] = per_req_i.rd && (per_req_i.addr == srv_pkg::ADDR_MBIN);
  end

  // User NMI sources: pin edge, oscillator fault as a level
  always_comb begin
    unmi_set = '0;
    unmi_set[srv_pkg::UI_NMI] = evt_i.nmi_pin && !st.nmi_pin_d;
    // Fault re-asserts while the oscillator stays bad, so a read cannot hide it
    unmi_set[srv_pkg::UI_OSC] = evt_i.osc_fault;
  end

  srv_prio_vec #(
    .N(srv_pkg::RST_N),
    .RST_VAL(RST_CAUSE_INIT)
  ) u_rst_vec (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .set_i(rst_set),
    .clr_i('0),
    .take_i(rd_rst),
    .code_o(rst_code),
    .pend_o()
  );

  srv_prio_vec #(
    .N(srv_pkg::NMI_N),
    .RST_VAL('0)
  ) u_snmi_vec (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .set_i(snmi_set),
    .clr_i(snmi_clr),
    .take_i(rd_snmi),
    .code_o(snmi_code),
    .pend_o(snmi_pend)
  );

  srv_prio_vec #(
    .N(srv_pkg::NMI_N),
    .RST_VAL('0)
  ) u_unmi_vec (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .set_i(unmi_set),
    .clr_i('0),
    .take_i(rd_unmi),
    .code_o(unmi_code),
    .pend_o(unmi_pend)
  );

  srv_wdog #(
    .CNT_W(WD_CNT_W)
  ) u_wdog (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sub_tick_i(st.sub_tick),
    .aux_tick_i(aux_tick_i),
    .vlo_tick_i(vlo_tick_i),
    .ssel_i(srv_pkg::srv_wck_t'(st.wd_ssel)),
    .hold_i(st.wd_hold),
    .clr_i(st.wd_clr),
    .isel_i(st.wd_isel),
    .expire_o(wd_expire)
  );

  always_comb begin
    next_st = st;
    next_st.wd_clr = 1'b0;
    next_st.irq = 1'b0;
    next_st.nmi_pin_d = evt_i.nmi_pin;
    next_st.snmi_p = snmi_pend;
    next_st.unmi_p = unmi_pend;

    // Sub-main clock enable derived from the system clock
    next_st.sub_tick = 1'b0;
    if (st.sub_cnt >= DIV_LAST) begin
      next_st.sub_cnt = 8'h00;
      next_st.sub_tick = 1'b1;
    end else begin
      next_st.sub_cnt = st.sub_cnt + 8'h01;
    end

    // Register reads; unmapped addresses return zero
    if (per_req_i.rd) begin
      case (per_req_i.addr)
        srv_pkg::ADDR_RST: next_st.rdata = rst_code;
        srv_pkg::ADDR_SNMI: next_st.rdata = snmi_code;
        srv_pkg::ADDR_UNMI: next_st.rdata = unmi_code;
        srv_pkg::ADDR_WDCTL: begin
          next_st.rdata = {8'h00, st.wd_hold, st.wd_ssel, st.wd_tmsel, 1'b0, 1'b0, st.wd_isel};
        end
        srv_pkg::ADDR_MBIN: next_st.rdata = st.mb_in;
        srv_pkg::ADDR_MBOUT: next_st.rdata = st.mb_out;
        default: next_st.rdata = 16'h0000;
      endcase
    end

    // Watchdog control; a bad key is not applied, and the clear pulse it triggers restores the defaults
    if (wd_write && !wd_pw_bad) begin
      next_st.wd_hold = per_req_i.wdata[srv_pkg::WD_HOLD];
      next_st.wd_ssel = per_req_i.wdata[srv_pkg::WD_SSEL_LO +: 2];
      next_st.wd_tmsel = per_req_i.wdata[srv_pkg::WD_TMSEL];
      next_st.wd_isel = per_req_i.wdata[srv_pkg::WD_IS_LO +: 2];
      next_st.wd_clr = per_req_i.wdata[srv_pkg::WD_CNTCL];
    end

    // Expiry: interrupt in interval mode, reset otherwise
    if (wd_expire && st.wd_tmsel) begin
      next_st.irq = 1'b1;
    end

    // Power-up clear pulse, stretched to a minimum width
    if (st.clr_cnt != 8'h00) begin
      next_st.clr_cnt = st.clr_cnt - 8'h01;
    end
    if ((wd_expire && !st.wd_tmsel) || wd_pw_bad) begin
      next_st.clr_cnt = CLR_LEN;
    end
    next_st.clr_pulse = (next_st.clr_cnt != 8'h00);
    if (st.clr_pulse) begin
      // Power-up clear returns the watchdog to defaults, counter included
      next_st.wd_hold = srv_pkg::WD_CTL_RST[srv_pkg::WD_HOLD];
      next_st.wd_ssel = srv_pkg::WD_CTL_RST[srv_pkg::WD_SSEL_LO +: 2];
      next_st.wd_tmsel = srv_pkg::WD_CTL_RST[srv_pkg::WD_TMSEL];
      next_st.wd_isel = srv_pkg::WD_CTL_RST[srv_pkg::WD_IS_LO +: 2];
      next_st.wd_clr = 1'b1;
    end

    // Mailbox: debug writes inbound word, application writes outbound word
    if (dbg_req_i.wr) begin
      next_st.mb_in = dbg_req_i.wdata;
    end
    if (per_req_i.wr && (per_req_i.addr == srv_pkg::ADDR_MBOUT)) begin
      next_st.mb_out = per_req_i.wdata;
      next_st.out_full = 1'b1;
    end else if (dbg_req_i.rd) begin
      next_st.out_full = 1'b0;
    end
    if (dbg_req_i.rd) begin
      next_st.dbg_rdata = st.mb_out;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign per_rdata_o = st.rdata;
  assign dbg_rdata_o = st.dbg_rdata;
  assign dbg_out_full_o = st.out_full;
  assign wdog_reset_o = st.clr_pulse;
  assign wdog_irq_o = st.irq;
  assign snmi_pend_o = st.snmi_p;
  assign unmi_pend_o = st.unmi_p;
endmodule

// ==== tb/srv_top_properties.sv ====
// Port-level checks for the reset and NMI vector unit
`timescale 1ns/1ps
module srv_top_properties (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input srv_pkg::srv_per_req_t per_req_i,
  input wire logic [15:0] per_rdata_o,
  input srv_pkg::srv_dbg_req_t dbg_req_i,
  input wire logic dbg_out_full_o,
  input wire logic wdog_reset_o,
  input wire logic wdog_irq_o,
  input wire logic snmi_pend_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  logic [15:0] addr;
  logic rd_v;
  logic wr_v;
  assign addr = per_req_i.addr;
  assign rd_v = per_req_i.rd;
  assign wr_v = per_req_i.wr;
  property p_unmapped;
    rd_v && !(addr inside {16'h015A, 16'h015C, 16'h015E, 16'h01CC, 16'h0120, 16'h0122}) |=> per_rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_code;
    rd_v && addr == 16'h015E |=> per_rdata_o inside {16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A,
      16'h000E, 16'h0014, 16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h001E, 16'h0020, 16'h0024};
  endproperty
  a_rst_code: assert property (p_rst_code) else $error("reset cause code not allowed");
  property p_snmi_code;
    rd_v && addr == 16'h015C |=> per_rdata_o inside {16'h0000, 16'h0002, 16'h0004, 16'h0012, 16'h0014, 16'h0016,
      16'h0018};
  endproperty
  a_snmi_code: assert property (p_snmi_code) else $error("system NMI code not allowed");
  property p_unmi_code;
    rd_v && addr == 16'h015A |=> per_rdata_o inside {16'h0000, 16'h0002, 16'h0004};
  endproperty
  a_unmi_code: assert property (p_unmi_code) else $error("user NMI code not allowed");
  property p_ctl_key;
    rd_v && addr == 16'h01CC |=> per_rdata_o[15:8] == 8'h00;
  endproperty
  a_ctl_key: assert property (p_ctl_key) else $error("watchdog key byte read back");
  property p_clr_width;
    $rose(wdog_reset_o) |-> wdog_reset_o [*4] ##1 !wdog_reset_o;
  endproperty
  a_clr_width: assert property (p_clr_width) else $error("watchdog reset width wrong");
  property p_bad_key;
    wr_v && addr == 16'h01CC && per_req_i.wdata[15:8] != 8'hA5 |-> ##[1:3] wdog_reset_o;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key gave no reset");
  property p_irq_pulse;
    wdog_irq_o |=> !wdog_irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interval interrupt longer than one cycle");
  property p_mb_in;
    dbg_req_i.wr |-> ##[1:3] snmi_pend_o;
  endproperty
  a_mb_in: assert property (p_mb_in) else $error("mailbox input gave no system NMI");
  property p_mb_out;
    dbg_req_i.rd && dbg_out_full_o && !(wr_v && addr == 16'h0122) |=> !dbg_out_full_o ##[0:2] snmi_pend_o;
  endproperty
  a_mb_out: assert property (p_mb_out) else $error("mailbox output event wrong");
  property p_mb_full;
    wr_v && addr == 16'h0122 |=> dbg_out_full_o;
  endproperty
  a_mb_full: assert property (p_mb_full) else $error("outbound word not flagged");
endmodule

bind srv_top srv_top_properties srv_top_properties_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .per_req_i(per_req_i), .per_rdata_o(per_rdata_o), .dbg_req_i(dbg_req_i), .dbg_out_full_o(dbg_out_full_o),
  .wdog_reset_o(wdog_reset_o), .wdog_irq_o(wdog_irq_o), .snmi_pend_o(snmi_pend_o));

// ==== tb/testbench.sv ====
// Directed tests for the reset and NMI vector unit
`timescale 1ns/1ps
module testbench;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  srv_pkg::srv_per_req_t per_req = '0;
  srv_pkg::srv_dbg_req_t dbg_req = '0;
  srv_pkg::srv_evt_t evt = '0;
  logic aux_tick = 1'b0;
  logic vlo_tick = 1'b0;
  logic [15:0] per_rdata;
  logic [15:0] dbg_rdata;
  logic dbg_full, wd_rst, wd_irq, snmi_pend, unmi_pend;
  int err_total = 0;
  int n_checks = 0;
  int tick_cnt = 0;
  int n;
  int tick_per [3] = '{2, 3, 5};
  logic [15:0] rst_exp [12] = '{16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000E, 16'h0014, 16'h001A,
    16'h001C, 16'h001E, 16'h0020, 16'h0024, 16'h0000};
  logic [15:0] snmi_exp [7] = '{16'h0002, 16'h0004, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h0000};

  always #25 sys_clk_i = ~sys_clk_i;

  srv_top srv_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .per_req_i(per_req), .per_rdata_o(per_rdata),
    .dbg_req_i(dbg_req), .dbg_rdata_o(dbg_rdata), .dbg_out_full_o(dbg_full), .evt_i(evt),
    .aux_tick_i(aux_tick), .vlo_tick_i(vlo_tick), .wdog_reset_o(wd_rst), .wdog_irq_o(wd_irq),
    .snmi_pend_o(snmi_pend), .unmi_pend_o(unmi_pend));

  // Auxiliary every 3 cycles, very-low every 5
  always @(posedge sys_clk_i) begin
    tick_cnt <= tick_cnt + 1;
    aux_tick <= (tick_cnt % 3) == 0;
    vlo_tick <= (tick_cnt % 5) == 0;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic r, input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    per_req <= '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge sys_clk_i);
    per_req <= '0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    acc(1'b1, 1'b0, a, 16'h0000);
    check(per_rdata, exp);
  endtask

  task automatic dbg(input logic r, input logic w, input logic [15:0] d);
    @(posedge sys_clk_i);
    dbg_req <= '{rd: r, wr: w, wdata: d};
    @(posedge sys_clk_i);
    dbg_req <= '0;
    #1;
  endtask

  task automatic pulse(input srv_pkg::srv_evt_t e);
    @(posedge sys_clk_i);
    evt <= e;
    @(posedge sys_clk_i);
    evt <= '0;
  endtask

  // Watchdog stays running after every reset, so stop it
  task automatic hold;
    acc(1'b0, 1'b1, 16'h01CC, 16'hA580);
  endtask

  task automatic wait_hi(input int lim, input logic sel_rst);
    n = 0;
    while (((sel_rst ? wd_rst : wd_irq) !== 1'b1) && n < lim) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_total++;
    report_and_stop;
  end

  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    hold;
    rd(16'h015E, 16'h0002);
    rd(16'h015E, 16'h0000);
    rd(16'h015C, 16'h0000);
    rd(16'h015A, 16'h0000);
    rd(16'h0200, 16'h0000);
    rd(16'h01CC, 16'h0080);
    $display("test defaults done");
    // Every event-input reset cause at once (no watchdog or brownout), then a write to the read-only vector
    pulse(srv_pkg::srv_evt_t'(16'hFFE0));
    acc(1'b0, 1'b1, 16'h015E, 16'h1234);
    foreach (rst_exp[i]) rd(16'h015E, rst_exp[i]);
    $display("test reset_cause done");
    pulse(srv_pkg::srv_evt_t'(16'h001C));
    dbg(1'b0, 1'b1, 16'h55AA);
    acc(1'b0, 1'b1, 16'h0122, 16'h1234);
    check(16'(dbg_full), 16'h0001);
    dbg(1'b1, 1'b0, 16'h0000);
    check(dbg_rdata, 16'h1234);
    check(16'(dbg_full), 16'h0000);
    check(16'(snmi_pend), 16'h0001);
    foreach (snmi_exp[i]) rd(16'h015C, snmi_exp[i]);
    dbg(1'b0, 1'b1, 16'hA55A);
    rd(16'h0120, 16'hA55A);
    rd(16'h015C, 16'h0000);
    check(16'(snmi_pend), 16'h0000);
    $display("test system_nmi done");
    pulse(srv_pkg::srv_evt_t'(16'h0003));
    @(posedge sys_clk_i);
    #1;
    check(16'(unmi_pend), 16'h0001);
    rd(16'h015A, 16'h0002);
    rd(16'h015A, 16'h0004);
    rd(16'h015A, 16'h0000);
    check(16'(unmi_pend), 16'h0000);
    // Pin held high flags once; oscillator fault re-flags while high
    @(posedge sys_clk_i);
    evt <= srv_pkg::srv_evt_t'(16'h0002);
    repeat (3) @(posedge sys_clk_i);
    evt <= '0;
    rd(16'h015A, 16'h0002);
    rd(16'h015A, 16'h0000);
    @(posedge sys_clk_i);
    evt <= srv_pkg::srv_evt_t'(16'h0001);
    rd(16'h015A, 16'h0004);
    rd(16'h015A, 16'h0004);
    @(posedge sys_clk_i);
    evt <= '0;
    rd(16'h015A, 16'h0004);
    rd(16'h015A, 16'h0000);
    $display("test user_nmi done");
    // Interval mode at the shortest tap on each clock source
    for (int k = 0; k < 3; k++) begin
      acc(1'b0, 1'b1, 16'h01CC, {8'hA5, 1'b0, k[1:0], 5'h1B});
      wait_hi(2000, 1'b0);
      check(16'(n >= 63 * tick_per[k] - 2 && n <= 65 * tick_per[k] + 3), 16'h0001);
      @(posedge sys_clk_i);
      #1;
      wait_hi(2000, 1'b0);
      check(16'(n + 1), 16'(64 * tick_per[k]));
      check(16'(wd_rst), 16'h0000);
    end
    // Tap of 2^9 sub-main ticks, then the reserved clock select never ticks
    acc(1'b0, 1'b1, 16'h01CC, 16'hA51A);
    wait_hi(1100, 1'b0);
    check(16'(n >= 1020 && n <= 1030), 16'h0001);
    acc(1'b0, 1'b1, 16'h01CC, 16'hA57B);
    wait_hi(300, 1'b0);
    check(16'(n), 16'h012C);
    hold;
    $display("test interval done");
    acc(1'b0, 1'b1, 16'h01CC, 16'hA50B);
    wait_hi(400, 1'b1);
    check(16'(n >= 120 && n <= 140), 16'h0001);
    wait_hi(0, 1'b1);
    n = 0;
    while (wd_rst === 1'b1 && n < 10) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    check(16'(n), 16'h0004);
    check(16'(wd_irq), 16'h0000);
    rd(16'h015E, 16'h0016);
    rd(16'h01CC, 16'h0000);
    hold;
    $display("test watchdog_reset done");
    acc(1'b0, 1'b1, 16'h01CC, 16'h5A80);
    wait_hi(5, 1'b1);
    check(16'(n <= 3), 16'h0001);
    repeat (6) @(posedge sys_clk_i);
    rd(16'h015E, 16'h0018);
    rd(16'h015E, 16'h0000);
    hold;
    $display("test bad_key done");
    // Reset in mid-run drops old causes and re-arms the brownout cause
    pulse(srv_pkg::srv_evt_t'(16'h8000));
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(16'h015E, 16'h0002);
    rd(16'h015E, 16'h0000);
    rd(16'h01CC, 16'h0000);
    check(16'(wd_rst), 16'h0000);
    $display("test mid_reset done");
    report_and_stop;
  end
endmodule
